// ### hw/adc_sequence_buffer_control.sv
// Notes on behaviour
// - Three-bit field selects reference pair.
// - Offset calibration ties inputs to negative reference.
// - Indexed mode stores result by channel; channels 22 and above have no slot and are not stored.
// - Scan mode steps through scan list.
// - Fill flag shows which half fills.
// - Interrupt after value-plus-one completed sequences.
// - Split mode uses two eleven-word halves.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_cfg.svh"
module adc_sequence_buffer_control
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Analog front end
  input  wire logic        conv_done,     // Pulse: one conversion finished
  input  wire logic [11:0] conv_result,   // Result of that conversion
  input  wire logic        seq_start,     // Pulse: a sample/convert sequence begins
  output var  logic [4:0]  mux_pos_sel,   // Positive mux input
  output var  logic        sha_to_vrefn,  // Tie sample inputs to negative reference
  output var  logic [2:0]  ref_sel,       // Reference pair select
  // Interrupt
  output var  logic        irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] seq_ctrl;                  // Control register, writable bits only
  logic [1:0]  irq_status;                // Sticky events
  logic [1:0]  irq_mask;                  // Interrupt enables
  logic [23:0] scan_list;                 // Inputs included in a scan
  logic [4:0]  chan_sel;                  // Fixed channel
  logic [11:0] buf_mem [`BUF_WORDS];      // Result buffer
  logic [4:0]  wr_ptr;                    // Next FIFO slot
  logic        half;                      // Half being filled
  logic [4:0]  scan_idx;                  // Current scan input
  seq_state_t  state;                     // Sequence in progress or idle
  logic        seq_irq;                   // Event from the sequence counter

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire [2:0] f_ref   = seq_ctrl[`POS_REF_LO+2:`POS_REF_LO];
  wire       f_cal   = seq_ctrl[`POS_OFFSET_CAL_ENABLE];
  wire       f_chidx = seq_ctrl[`POS_CHIDX];
  wire       f_scan  = seq_ctrl[`POS_SCAN];
  wire [3:0] f_spi   = seq_ctrl[`POS_SPI_LO+3:`POS_SPI_LO];
  wire       f_split = seq_ctrl[`POS_SPLIT];
  wire       acc     = psel && penable;
  wire       wr_en   = acc && pwrite;

  // Next set scan input after the given one, wrapping
  function automatic logic [4:0] next_scan(input logic [4:0] cur, input logic [23:0] lst);
    logic [4:0] res;
    logic       found;
    logic [4:0] cand;
    res = cur;
    found = 1'b0;
    for (int i = 1; i <= `NUM_INPUTS; i++)
    begin
      cand = 5'((int'(cur) + i) % `NUM_INPUTS);
      if (!found && lst[cand])
      begin
        res = cand;
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // Buffer slot for this result
  wire [4:0] half_base = half ? 5'(`HALF_WORDS) : 5'h00;
  wire [4:0] slot      = f_chidx ? mux_pos_sel : (f_split ? half_base + wr_ptr : wr_ptr);
  wire [4:0] fill_len  = f_split ? 5'(`HALF_WORDS) : 5'(`BUF_WORDS);
  wire       last_slot = (wr_ptr == fill_len - 5'h01);
  wire [4:0] next_chan = f_scan ? next_scan(scan_idx, scan_list) : chan_sel;
  // Lowest listed input: the search wraps from the top input round to input 0
  wire [4:0] first_scan = next_scan(5'(`NUM_INPUTS - 1), scan_list);
  wire       seq_end   = conv_done && (!f_scan || next_scan(scan_idx, scan_list) <= scan_idx);
  wire [31:0] ctrl_rd  = (seq_ctrl & `SEQ_CTRL_WMASK) | (32'(half && f_split) << `POS_HALF);
  wire [31:0] buf_word = (paddr >= 12'h100 && paddr < 12'h100 + 12'(4*`BUF_WORDS))
                         ? {20'h0, buf_mem[5'(paddr[11:2] - 10'h040)]} : 32'h0;

  // ----------------------------------------------------------------
  // APB register write and read
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_ctrl  <= `SEQ_CTRL_RESET;
      irq_mask  <= 2'h0;
      scan_list <= 24'h000000;
      chan_sel  <= 5'h00;
      prdata    <= 32'h0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (wr_en && pready)
      begin
        unique case (paddr)
          `OFF_SEQ_CTRL:  seq_ctrl  <= pwdata & `SEQ_CTRL_WMASK;
          `OFF_IRQ_MASK:  irq_mask  <= pwdata[1:0];
          `OFF_SCAN_LIST: scan_list <= pwdata[23:0];
          `OFF_CHAN_SEL:  chan_sel  <= pwdata[4:0];
          default:        ;
        endcase
      end
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          `OFF_SEQ_CTRL:   prdata <= ctrl_rd;
          `OFF_IRQ_STATUS: prdata <= {30'h0, irq_status};
          `OFF_IRQ_MASK:   prdata <= {30'h0, irq_mask};
          `OFF_SCAN_LIST:  prdata <= {8'h0, scan_list};
          `OFF_CHAN_SEL:   prdata <= {27'h0, chan_sel};
          default:         prdata <= buf_word;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencing, buffer fill and front end drive
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr       <= 5'h00;
      half         <= 1'b0;
      scan_idx     <= 5'h00;
      mux_pos_sel  <= 5'h00;
      sha_to_vrefn <= 1'b0;
      ref_sel      <= 3'h0;
      state        <= st_idle;
    end
    else
    begin
      ref_sel      <= f_ref;
      sha_to_vrefn <= f_cal;
      if (seq_start)
        state <= st_busy;
      if (conv_done)
      begin
        buf_mem[slot] <= conv_result;
        scan_idx      <= next_chan;
        mux_pos_sel   <= next_chan;
        if (last_slot || seq_end)
        begin
          wr_ptr <= 5'h00;
          if (f_split)
            half <= !half;
        end
        else
          wr_ptr <= wr_ptr + 5'h01;
        if (seq_end)
          state <= st_idle;
      end
      else if (state == st_idle)
      begin
        // Park the mux on the first input of the next sequence, never a stale one
        mux_pos_sel <= f_scan ? first_scan : chan_sel;
        scan_idx    <= first_scan;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, set wins over write-one clear
  // ----------------------------------------------------------------
  wire [1:0] ev = {conv_done && last_slot && !f_chidx, seq_irq};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= 2'h0;
      irq        <= 1'b0;
    end
    else
    begin
      irq_status <= (irq_status & ~((wr_en && pready && paddr == `OFF_IRQ_STATUS)
                    ? pwdata[1:0] : 2'h0)) | ev;
      irq        <= |(irq_status & irq_mask);
    end
  end

  seq_irq_counter u_cnt (
    .pclk      (pclk),
    .presetn   (presetn),
    .seq_limit (f_spi),
    .seq_done  (seq_end),
    .irq_event (seq_irq)
  );

  property p_cal_tie;
    @(posedge pclk) disable iff (!presetn)
    f_cal |=> sha_to_vrefn;
  endproperty
  a_cal_tie: assert property (p_cal_tie)
    else $error("calibration did not tie inputs");

  property p_ref_follow;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (ref_sel == $past(f_ref));
  endproperty
  a_ref_follow: assert property (p_ref_follow)
    else $error("reference select not applied");

  property p_half_toggle;
    @(posedge pclk) disable iff (!presetn)
    (conv_done && f_split && last_slot) |=> (half != $past(half));
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("split half did not swap");

  property p_unimpl_zero;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_rd & ~(`SEQ_CTRL_WMASK | 32'h80)) == 32'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("unimplemented bit reads nonzero");

  property p_fixed_chan;
    @(posedge pclk) disable iff (!presetn)
    (conv_done && !f_scan) |=> (mux_pos_sel == $past(chan_sel));
  endproperty
  a_fixed_chan: assert property (p_fixed_chan)
    else $error("fixed channel not held");

  property p_chidx_slot;
    @(posedge pclk) disable iff (!presetn)
    (conv_done && f_chidx && (mux_pos_sel < 5'(`BUF_WORDS)))
      |=> (buf_mem[$past(mux_pos_sel)] == $past(conv_result));
  endproperty
  a_chidx_slot: assert property (p_chidx_slot)
    else $error("indexed slot mismatch");

  property p_half_flag;
    @(posedge pclk) disable iff (!presetn)
    !f_split |-> !ctrl_rd[`POS_HALF];
  endproperty
  a_half_flag: assert property (p_half_flag)
    else $error("fill flag set outside split mode");

  property p_scan_member;
    @(posedge pclk) disable iff (!presetn)
    (conv_done && f_scan && (scan_list != 24'h000000)) |=> scan_list[mux_pos_sel];
  endproperty
  a_scan_member: assert property (p_scan_member)
    else $error("scan left the selected list");
endmodule
`default_nettype wire

// ### hw/adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
// Register byte addresses
`define OFF_SEQ_CTRL     12'h000
`define OFF_IRQ_STATUS   12'h004
`define OFF_IRQ_MASK     12'h008
`define OFF_FRONT_END    12'h00C
`define OFF_SCAN_LIST    12'h010
`define OFF_CHAN_SEL     12'h014
// Control register field positions
`define POS_REF_LO       13
`define POS_OFFSET_CAL_ENABLE       12
`define POS_CHIDX        11
`define POS_SCAN         10
`define POS_HALF         7
`define POS_SPI_LO       2
`define POS_SPLIT        1
// Writable bits of the control register
`define SEQ_CTRL_WMASK   32'h0000_FC3E
`define SEQ_CTRL_RESET   32'h0000_0000
// Buffer geometry
`define BUF_WORDS        22
`define HALF_WORDS       11
`define NUM_INPUTS       24
// Interrupt status bits
`define IRQ_SEQ_BIT      0
`define IRQ_OVF_BIT      1
`endif

// ### hw/adc_seq_pkg.sv
package adc_seq_pkg;
  // Reference pair encodings
  typedef enum logic [2:0] {
    ref_supply   = 3'h0,
    ref_ext_neg  = 3'h1,
    ref_ext_pos  = 3'h2,
    ref_ext_both = 3'h3
  } ref_sel_t;
  // Scan sequencer state
  typedef enum logic [0:0] {
    st_idle,
    st_busy
  } seq_state_t;
endpackage

// ### hw/seq_irq_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_cfg.svh"
module seq_irq_counter
  import adc_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [3:0] seq_limit,   // Sequences per interrupt minus one
  input  wire logic       seq_done,    // One completed sample/convert sequence
  // Event
  output var  logic       irq_event    // Pulse after every limit+1 sequences
);
  logic [3:0] seq_count;               // Sequences seen since last event
  wire        at_limit = (seq_count >= seq_limit);

  // Count sequences, fire and restart at the limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_count <= 4'h0;
      irq_event <= 1'b0;
    end
    else
    begin
      irq_event <= seq_done && at_limit;
      if (seq_done)
        seq_count <= at_limit ? 4'h0 : seq_count + 4'h1;
    end
  end

  property p_irq_after_limit;
    @(posedge pclk) disable iff (!presetn)
    (seq_done && at_limit) |=> irq_event;
  endproperty
  a_irq_after_limit: assert property (p_irq_after_limit)
    else $error("sequence interrupt not raised at limit");

  property p_no_irq_early;
    @(posedge pclk) disable iff (!presetn)
    (seq_done && !at_limit) |=> !irq_event;
  endproperty
  a_no_irq_early: assert property (p_no_irq_early)
    else $error("sequence interrupt raised early");
endmodule
`default_nettype wire

// ### bench/fe_model.sv
`timescale 1ns/1ps
`default_nettype none
module fe_model (
  // Clock
  input  wire logic        pclk,
  // Conversion events towards the block
  output var  logic        conv_done,
  output var  logic        seq_start,
  output var  logic [11:0] conv_result
);
  // Quiet front end at time zero
  initial
  begin
    conv_done   = 1'b0;
    seq_start   = 1'b0;
    conv_result = 12'h000;
  end
  // One sequence start, then one finished conversion
  task automatic convert(input logic [11:0] r);
    @(posedge pclk) seq_start <= 1'b1;
    @(posedge pclk) seq_start <= 1'b0;
    conv_done   <= 1'b1;
    conv_result <= r;
    @(posedge pclk) conv_done <= 1'b0;
    conv_result <= ~r; // Result is not held after its pulse
  endtask
endmodule
`default_nettype wire

// ### bench/adc_sequence_buffer_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_cfg.svh"
module adc_sequence_buffer_control_tb_top;
  import adc_seq_pkg::*;
  // Bus, front end and bookkeeping
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        conv_done, seq_start, sha_to_vrefn, irq;
  logic [11:0] paddr, conv_result;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  mux_pos_sel, prev;
  logic [2:0]  ref_sel;
  int          error_cnt, total_checks;

  adc_sequence_buffer_control uut (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .conv_done    (conv_done),
    .conv_result  (conv_result),
    .seq_start    (seq_start),
    .mux_pos_sel  (mux_pos_sel),
    .sha_to_vrefn (sha_to_vrefn),
    .ref_sel      (ref_sel),
    .irq          (irq)
  );
  fe_model fe (
    .pclk        (pclk),
    .conv_done   (conv_done),
    .seq_start   (seq_start),
    .conv_result (conv_result)
  );

  // 25 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
    chk(pslverr, 1'b0);
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
    #1;
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdc(`OFF_SEQ_CTRL, 32'h0000_0000);
    apb(1'b1, `OFF_SEQ_CTRL, 32'hFFFF_7FFF);
    rdc(`OFF_SEQ_CTRL, 32'h0000_7C3E);
    chk(sha_to_vrefn, 1'b1);
    apb(1'b1, `OFF_FRONT_END, 32'hFFFF_FFFF);
    rdc(`OFF_FRONT_END, 32'h0000_0000);
    apb(1'b1, `OFF_SEQ_CTRL, 32'h0000_0000);
    settle();
    chk(sha_to_vrefn, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, `OFF_SEQ_CTRL, 32'(i) << 13);
      settle();
      chk(ref_sel, 3'(i));
    end
  endtask
  // Interrupt every third sequence, clear, then masked
  task automatic t_irq();
    apb(1'b1, `OFF_IRQ_MASK, 32'h0000_0001);
    apb(1'b1, `OFF_SEQ_CTRL, 32'h0000_0008);
    repeat (2) fe.convert(12'h111);
    settle();
    chk(irq, 1'b0);
    fe.convert(12'h222);
    settle();
    chk(irq, 1'b1);
    apb(1'b1, `OFF_IRQ_STATUS, 32'h0000_0001);
    settle();
    chk(irq, 1'b0);
    apb(1'b1, `OFF_IRQ_MASK, 32'h0000_0000);
    repeat (3) fe.convert(12'h333);
    settle();
    chk(irq, 1'b0);
    apb(1'b0, `OFF_IRQ_STATUS, 32'h0000_0000);
    chk(rd[0], 1'b1);
  endtask
  // Fixed channel: each conversion is a sequence and restarts at slot 0
  task automatic t_store();
    apb(1'b1, `OFF_CHAN_SEL, 32'h0000_0003);
    settle();
    chk(mux_pos_sel, 5'h03);
    fe.convert(12'hABC);
    rdc(12'h100, 32'h0000_0ABC);
    fe.convert(12'h123);
    rdc(12'h100, 32'h0000_0123);
    apb(1'b1, `OFF_SEQ_CTRL, 32'h0000_0800);
    apb(1'b1, `OFF_CHAN_SEL, 32'h0000_0007);
    fe.convert(12'h5A5);
    rdc(12'h11C, 32'h0000_05A5);
  endtask
  // Scan list of inputs 2 and 4 alternates, from input 2, in FIFO order
  task automatic t_scan();
    apb(1'b1, `OFF_SCAN_LIST, 32'h0000_0014);
    apb(1'b1, `OFF_SEQ_CTRL, 32'h0000_0400);
    settle();
    chk(mux_pos_sel, 5'h02);
    prev = 5'h02;
    for (int i = 0; i < 4; i++)
    begin
      fe.convert(12'h0F0 + 12'(i));
      settle();
      chk(mux_pos_sel === 5'h02 || mux_pos_sel === 5'h04, 1'b1);
      chk(mux_pos_sel !== prev, 1'b1);
      prev = mux_pos_sel;
    end
    rdc(12'h100, 32'h0000_00F2);
    rdc(12'h104, 32'h0000_00F3);
  endtask
  // Split buffer: halves alternate per sequence, fill flag follows
  task automatic t_split();
    apb(1'b1, `OFF_SEQ_CTRL, 32'h0000_0002);
    rdc(`OFF_SEQ_CTRL, 32'h0000_0002);
    fe.convert(12'h777);
    settle();
    rdc(`OFF_SEQ_CTRL, 32'h0000_0082);
    rdc(12'h100, 32'h0000_0777);
    fe.convert(12'h778);
    settle();
    rdc(12'h12C, 32'h0000_0778);
    rdc(`OFF_SEQ_CTRL, 32'h0000_0002);
  endtask

  // Watchdog
  initial
  begin
    #400000;
    error_cnt++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr  = 12'h000;
    pwdata = 32'h0000_0000;
    do_reset();
    t_regs();
    t_irq();
    do_reset();
    t_store();
    t_scan();
    t_split();
    wrap_up();
  end
endmodule
`default_nettype wire
